// ==== core/spm_boot_loader.v ====
// Serial EEPROM reader for satellite boot
`timescale 1ns/1ps
`include "spm_map.vh"
module spm_boot_loader (
   input wire i_clock,
   input wire i_reset,
   input wire i_start,
   input wire i_data_in,
   output reg o_clock,
   output reg o_data_out,
   output reg o_select,
   output reg o_busy,
   output reg o_done,
   output reg o_we,
   output reg [`SPM_ADDR_W-1:0] o_addr,
   output reg [`SPM_WORD_W-1:0] o_wdata
);
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_SHIFT = 4'h2;
   localparam [3:0] ST_GAP = 4'h4;
   localparam [3:0] ST_DONE = 4'h8;
   localparam integer HALF_CYC = `SPM_SK_HALF_CYC;
   localparam [7:0] HALF = HALF_CYC[7:0];

   reg [3:0] state_reg;
   reg [7:0] div_reg;
   reg [4:0] bit_reg;
   reg [`SPM_CMD_BITS-1:0] cmd_reg;
   reg [`SPM_WORD_W-1:0] data_reg;
   wire tick = (div_reg == HALF - 8'h01);
   wire [`SPM_CMD_BITS-1:0] cmd_word;

   assign cmd_word = {`SPM_READ_OP, 2'h0, o_addr};

   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         state_reg <= ST_IDLE;
         div_reg <= 8'h00;
         bit_reg <= 5'h00;
         cmd_reg <= {`SPM_CMD_BITS{1'b0}};
         data_reg <= {`SPM_WORD_W{1'b0}};
         o_clock <= 1'b0;
         o_data_out <= 1'b0;
         o_select <= 1'b0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_we <= 1'b0;
         o_addr <= {`SPM_ADDR_W{1'b0}};
         o_wdata <= {`SPM_WORD_W{1'b0}};
      end else begin
         o_we <= 1'b0;
         div_reg <= tick ? 8'h00 : div_reg + 8'h01;
         case (state_reg)
            ST_IDLE: begin
               div_reg <= 8'h00;
               if (i_start) begin
                  state_reg <= ST_GAP;
                  o_busy <= 1'b1;
                  o_done <= 1'b0;
                  o_addr <= {`SPM_ADDR_W{1'b0}};
               end
            end
            ST_GAP: begin
               // Deselect for one half period so each word is its own read
               if (tick) begin
                  state_reg <= ST_SHIFT;
                  o_select <= 1'b1;
                  bit_reg <= 5'h00;
                  cmd_reg <= {cmd_word[`SPM_CMD_BITS-2:0], 1'b0};
                  o_data_out <= cmd_word[`SPM_CMD_BITS-1];
               end
            end
            ST_SHIFT: begin
               if (tick && !o_clock) begin
                  o_clock <= 1'b1;
                  if (bit_reg >= `SPM_DATA_FIRST) begin
                     data_reg <= {data_reg[`SPM_WORD_W-2:0], i_data_in};
                  end
               end else if (tick) begin
                  o_clock <= 1'b0;
                  o_data_out <= cmd_reg[`SPM_CMD_BITS-1];
                  cmd_reg <= {cmd_reg[`SPM_CMD_BITS-2:0], 1'b0};
                  bit_reg <= bit_reg + 5'h01;
                  if (bit_reg == `SPM_XFER_BITS - 1) begin
                     o_select <= 1'b0;
                     o_data_out <= 1'b0;
                     o_we <= 1'b1;
                     o_wdata <= data_reg;
                     state_reg <= (o_addr == `SPM_WORDS - 1) ?
                        ST_DONE : ST_GAP;
                  end
               end
            end
            ST_DONE: begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
               o_addr <= o_addr + {{(`SPM_ADDR_W-1){1'b0}}, 1'b1};
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
         if (o_we && state_reg != ST_DONE && state_reg != ST_IDLE) begin
            o_addr <= o_addr + {{(`SPM_ADDR_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

// ==== core/spm_cfg_mem.v ====
// Configuration word store filled by the boot loader
`timescale 1ns/1ps
`include "spm_map.vh"
module spm_cfg_mem (
   input wire i_clock,
   input wire i_we,
   input wire [`SPM_ADDR_W-1:0] i_waddr,
   input wire [`SPM_WORD_W-1:0] i_wdata,
   input wire [`SPM_ADDR_W-1:0] i_raddr,
   output reg [`SPM_WORD_W-1:0] o_rdata
);
   reg [`SPM_WORD_W-1:0] mem [0:`SPM_WORDS-1];

   // No reset on the array; contents are only meaningful after a load
   always @(posedge i_clock) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule

// ==== core/spm_map.vh ====
// Constants for the serial pin function multiplexer
// Overview of operation
// - Both transmit pins come up as inputs
// - Transmit 0 on bit 5, transmit 1 on bit 3
// - Modem lines on bits 15 to 12
// - Data-out on bit 10, driven low at reset
// - Data-in on bit 7, input at reset
// - Serial clock on bit 9, low at reset
// - Select on bit 8, held high at reset
// - Satellite boot loads configuration from EEPROM
// - Five maskable interrupt inputs are active low
// - Cold reset latches the initialization vectors
// - Free shared bits are plain inputs or outputs
`ifndef SPM_MAP_VH
`define SPM_MAP_VH

// Pad slots on the pad bus
`define SPM_PAD_TX0 0
`define SPM_PAD_TX1 1
`define SPM_PAD_CTS 2
`define SPM_PAD_DSR 3
`define SPM_PAD_DTR 4
`define SPM_PAD_RTS 5
`define SPM_PAD_DOUT 6
`define SPM_PAD_DIN 7
`define SPM_PAD_SCK 8
`define SPM_PAD_SEL 9
`define SPM_PADS 10

// General-purpose bit behind each pad slot, slot 0 in the low nibble
`define SPM_PIO_OF_PAD 40'h897AC_DEF35

// Pads whose peripheral function drives the pin
`define SPM_PERIPH_DRIVES 10'h373

// Reset values of the general-purpose control words
`define SPM_FUNC_RST 16'h0000
`define SPM_DIR_RST 16'h0700
`define SPM_OUT_RST 16'h0100

// Initialization vector
`define SPM_VEC_W 32
`define SPM_VEC_SAT_BIT 0

// Boot EEPROM access
`define SPM_CLK_NS 10
`define SPM_SK_HALF_NS 500
`define SPM_SK_HALF_CYC ((`SPM_SK_HALF_NS + `SPM_CLK_NS - 1) / `SPM_CLK_NS)
`define SPM_CMD_BITS 9
`define SPM_XFER_BITS 26
`define SPM_DATA_FIRST 10
`define SPM_READ_OP 3'h6
`define SPM_WORDS 16
`define SPM_WORD_W 16
`define SPM_ADDR_W 4

`endif

// ==== core/spm_map_unused_none.v ====
`timescale 1ns/1ps

// ==== core/spm_pin_mux.v ====
// Pin function multiplexer for the serial-port pins
`timescale 1ns/1ps
`include "spm_map.vh"
module spm_pin_mux (
   input wire i_clock,
   input wire i_reset,
   input wire i_coldreset_n,
   input wire [`SPM_VEC_W-1:0] i_init_vector,
   input wire i_cfg_write,
   input wire [15:0] i_pio_func,
   input wire [15:0] i_pio_dir,
   input wire [15:0] i_pio_out,
   input wire [1:0] i_uart_tx,
   input wire i_uart_dtr_n,
   input wire i_uart_rts_n,
   input wire i_spi_data_out,
   input wire i_spi_clock,
   input wire i_spi_sel_n,
   input wire [`SPM_PADS-1:0] i_pad_in,
   input wire i_nmi_n,
   input wire [4:0] i_int_n,
   input wire [`SPM_ADDR_W-1:0] i_cfg_raddr,
   output reg [`SPM_PADS-1:0] o_pad_out,
   output reg [`SPM_PADS-1:0] o_pad_oe,
   output reg [15:0] o_pio_in,
   output reg [15:0] o_pio_func,
   output reg [15:0] o_pio_dir,
   output reg o_uart_cts_n,
   output reg o_uart_dsr_n,
   output reg o_spi_data_in,
   output reg o_nmi_req,
   output reg [4:0] o_int_req,
   output reg [`SPM_VEC_W-1:0] o_init_vector,
   output reg o_cold_active,
   output reg o_boot_busy,
   output reg o_boot_done,
   output wire [`SPM_WORD_W-1:0] o_cfg_rdata
);
   localparam [39:0] PIO_MAP = `SPM_PIO_OF_PAD;
   localparam [`SPM_PADS-1:0] PERIPH_DRV = `SPM_PERIPH_DRIVES;

   reg [15:0] func_reg;
   reg [15:0] dir_reg;
   reg [15:0] out_reg;
   reg cold_q_reg;
   reg start_reg;
   reg [`SPM_PADS-1:0] periph_out;
   wire boot_clock;
   wire boot_data_out;
   wire boot_select;
   wire boot_busy;
   wire boot_done;
   wire mem_we;
   wire [`SPM_ADDR_W-1:0] mem_addr;
   wire [`SPM_WORD_W-1:0] mem_wdata;
   wire [`SPM_PADS-1:0] pad_out_next;
   wire [`SPM_PADS-1:0] pad_oe_next;
   wire [15:0] pio_in_next;

   // Control words: defaults leave every shared bit on its general-purpose
   // function with the required reset direction and level
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         func_reg <= `SPM_FUNC_RST;
         dir_reg <= `SPM_DIR_RST;
         out_reg <= `SPM_OUT_RST;
      end else if (!i_coldreset_n) begin
         func_reg <= `SPM_FUNC_RST;
         dir_reg <= `SPM_DIR_RST;
         out_reg <= `SPM_OUT_RST;
      end else if (i_cfg_write) begin
         // Software reconfiguration is the only way to enable transmit
         func_reg <= i_pio_func;
         dir_reg <= i_pio_dir;
         out_reg <= i_pio_out;
      end
   end

   // Cold reset: vectors follow the strap pins while it is held and freeze
   // at release; a release with the satellite strap starts the boot load
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         // Idle level of the pin, so no false release follows reset
         cold_q_reg <= 1'b1;
         start_reg <= 1'b0;
         o_init_vector <= {`SPM_VEC_W{1'b0}};
         o_cold_active <= 1'b1;
      end else begin
         cold_q_reg <= i_coldreset_n;
         o_cold_active <= ~i_coldreset_n;
         if (!i_coldreset_n) begin
            o_init_vector <= i_init_vector;
         end
         start_reg <= i_coldreset_n && !cold_q_reg &&
            o_init_vector[`SPM_VEC_SAT_BIT];
      end
   end

   // Peripheral drive values per pad slot
   always @* begin
      periph_out = {`SPM_PADS{1'b0}};
      periph_out[`SPM_PAD_TX0] = i_uart_tx[0];
      periph_out[`SPM_PAD_TX1] = i_uart_tx[1];
      periph_out[`SPM_PAD_DTR] = i_uart_dtr_n;
      periph_out[`SPM_PAD_RTS] = i_uart_rts_n;
      periph_out[`SPM_PAD_DOUT] = i_spi_data_out;
      periph_out[`SPM_PAD_SCK] = i_spi_clock;
      periph_out[`SPM_PAD_SEL] = i_spi_sel_n;
   end

   // Per pad: boot loader first, then peripheral, then general-purpose bit
   genvar g;
   generate
      for (g = 0; g < `SPM_PADS; g = g + 1) begin : g_pad
         localparam [3:0] BIT = PIO_MAP[4*g+3:4*g];
         wire is_boot_pin;
         wire is_func;
         assign is_boot_pin = boot_busy && (g == `SPM_PAD_DOUT ||
            g == `SPM_PAD_SCK || g == `SPM_PAD_DIN ||
            g == `SPM_PAD_SEL);
         assign is_func = func_reg[BIT];
         assign pad_oe_next[g] = is_boot_pin ? (g != `SPM_PAD_DIN) :
            is_func ? PERIPH_DRV[g] : dir_reg[BIT];
         assign pad_out_next[g] = is_boot_pin ?
            ((g == `SPM_PAD_DOUT) ? boot_data_out :
             (g == `SPM_PAD_SCK) ? boot_clock :
             (g == `SPM_PAD_SEL) ? boot_select : 1'b0) :
            is_func ? periph_out[g] : out_reg[BIT];
         assign pio_in_next[BIT] = (is_func || is_boot_pin) ?
            1'b0 : i_pad_in[g];
      end
   endgenerate

   // Bits 0..2, 4, 6 and 11 belong to pins handled elsewhere
   assign pio_in_next[0] = 1'b0;
   assign pio_in_next[1] = 1'b0;
   assign pio_in_next[2] = 1'b0;
   assign pio_in_next[4] = 1'b0;
   assign pio_in_next[6] = 1'b0;
   assign pio_in_next[11] = 1'b0;

   // All pad drives are registered so the pins never glitch on mux changes
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_pad_oe <= {`SPM_PADS{1'b0}};
         o_pad_out <= {`SPM_PADS{1'b0}};
         o_pad_oe[`SPM_PAD_DOUT] <= 1'b1;
         o_pad_oe[`SPM_PAD_SCK] <= 1'b1;
         o_pad_oe[`SPM_PAD_SEL] <= 1'b1;
         o_pad_out[`SPM_PAD_SEL] <= 1'b1;
         o_pio_in <= 16'h0000;
         o_pio_func <= `SPM_FUNC_RST;
         o_pio_dir <= `SPM_DIR_RST;
      end else begin
         o_pad_oe <= pad_oe_next;
         o_pad_out <= pad_out_next;
         o_pio_in <= pio_in_next;
         o_pio_func <= func_reg;
         o_pio_dir <= dir_reg;
      end
   end

   // Inputs routed to the peripherals; modem lines idle high and data-in idles low when not selected
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_uart_cts_n <= 1'b1;
         o_uart_dsr_n <= 1'b1;
         o_spi_data_in <= 1'b0;
      end else begin
         o_uart_cts_n <= func_reg[15] ? i_pad_in[`SPM_PAD_CTS] : 1'b1;
         o_uart_dsr_n <= func_reg[14] ? i_pad_in[`SPM_PAD_DSR] : 1'b1;
         o_spi_data_in <= (func_reg[7] && !boot_busy) ?
            i_pad_in[`SPM_PAD_DIN] : 1'b0;
      end
   end

   // Active-low interrupt pins become active-high requests
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_nmi_req <= 1'b0;
         o_int_req <= 5'h00;
      end else begin
         o_nmi_req <= ~i_nmi_n;
         o_int_req <= ~i_int_n;
      end
   end

   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_boot_busy <= 1'b0;
         o_boot_done <= 1'b0;
      end else begin
         o_boot_busy <= boot_busy;
         o_boot_done <= boot_done;
      end
   end

   spm_boot_loader u_loader (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_start(start_reg),
      .i_data_in(i_pad_in[`SPM_PAD_DIN]),
      .o_clock(boot_clock),
      .o_data_out(boot_data_out),
      .o_select(boot_select),
      .o_busy(boot_busy),
      .o_done(boot_done),
      .o_we(mem_we),
      .o_addr(mem_addr),
      .o_wdata(mem_wdata)
   );

   spm_cfg_mem u_mem (
      .i_clock(i_clock),
      .i_we(mem_we),
      .i_waddr(mem_addr),
      .i_wdata(mem_wdata),
      .i_raddr(i_cfg_raddr),
      .o_rdata(o_cfg_rdata)
   );
endmodule

// ==== testbench/spm_eeprom_model.sv ====
// Behavioural boot EEPROM seen through the pads
`timescale 1ns/1ps
module spm_eeprom_model (
   input wire i_sck,
   input wire i_sel,
   input wire i_mosi,
   output reg o_miso
);
   integer cnt = 0;
   reg [8:0] cmd = 9'h000;
   reg [15:0] w;
   initial o_miso = 1'b0;
   always @(posedge i_sel) cnt = 0;
   // A released line never keeps showing its last bit
   always @(negedge i_sel) o_miso = ~o_miso;
   always @(posedge i_sck) begin
      if (i_sel && cnt < 9) cmd = {cmd[7:0], i_mosi};
      if (i_sel) cnt = cnt + 1;
   end
   always @(negedge i_sck) begin
      w = {4{cmd[3:0]}} ^ 16'h5A3C;
      // A wrong opcode returns inverted data so the store shows it
      if (cmd[8:4] != 5'h18) w = ~w;
      if (i_sel && cnt >= 10 && cnt < 26) o_miso = w[25 - cnt];
   end
endmodule

// ==== testbench/spm_pin_mux_properties.sv ====
// Port-level assertions for the serial pin multiplexer
`timescale 1ns/1ps
module spm_pin_mux_properties (
   input wire i_clock,
   input wire i_reset,
   input wire i_coldreset_n,
   input wire [31:0] i_init_vector,
   input wire i_cfg_write,
   input wire [15:0] i_pio_func,
   input wire [1:0] i_uart_tx,
   input wire [4:0] i_int_n,
   input wire [9:0] o_pad_out,
   input wire [9:0] o_pad_oe,
   input wire [15:0] o_pio_func,
   input wire [4:0] o_int_req,
   input wire [31:0] o_init_vector,
   input wire o_boot_busy
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_reset);
   sequence s_cold_rel;
      (!i_coldreset_n) ##1 (i_coldreset_n && o_init_vector[0]);
   endsequence
   property p_rst_pads;
      $fell(i_reset) |->
         o_pad_oe == 10'h340 && (o_pad_out & o_pad_oe) == 10'h200;
   endproperty
   // Cold reset needs three edges: control words, then the pad stage
   property p_cold_dflt;
      (!i_coldreset_n) [*3] |-> o_pad_oe == 10'h340 && o_pio_func == 16'h0000;
   endproperty
   property p_cfg_lat;
      (i_cfg_write && i_coldreset_n) ##1 i_coldreset_n |=>
         o_pio_func == $past(i_pio_func, 2);
   endproperty
   property p_tx_pass;
      o_pio_func[5] |-> o_pad_oe[0] && o_pad_out[0] == $past(i_uart_tx[0]);
   endproperty
   property p_int_lvl;
      !$stable(i_int_n) |=> o_int_req == ~$past(i_int_n);
   endproperty
   property p_vec_track;
      !i_coldreset_n |=> o_init_vector == $past(i_init_vector);
   endproperty
   property p_boot_start;
      s_cold_rel |-> ##[1:4] o_boot_busy;
   endproperty
   property p_boot_pads;
      o_boot_busy |-> o_pad_oe[8] && o_pad_oe[6] && !o_pad_oe[7];
   endproperty
   a_rst_pads: assert property (p_rst_pads)
      else $error("pads not at reset state");
   a_cold_dflt: assert property (p_cold_dflt)
      else $error("cold reset left control words");
   a_cfg_lat: assert property (p_cfg_lat)
      else $error("function word not taken");
   a_tx_pass: assert property (p_tx_pass)
      else $error("transmit 0 not on its pad");
   a_int_lvl: assert property (p_int_lvl)
      else $error("interrupt request level wrong");
   a_vec_track: assert property (p_vec_track)
      else $error("vector not captured");
   a_boot_start: assert property (p_boot_start)
      else $error("boot load did not start");
   a_boot_pads: assert property (p_boot_pads)
      else $error("boot does not own the pads");
endmodule

// ==== testbench/spm_pin_mux_tb.sv ====
// Self-checking bench for the serial pin multiplexer
`timescale 1ns/1ps
`include "spm_map.vh"
module spm_pin_mux_tb;
   reg i_clock = 1'b0, i_reset = 1'b1, i_coldreset_n = 1'b1;
   reg i_cfg_write = 1'b0, i_uart_dtr_n = 1'b1, i_uart_rts_n = 1'b1;
   reg i_spi_data_out = 1'b0, i_spi_clock = 1'b0, i_spi_sel_n = 1'b1;
   reg i_nmi_n = 1'b1, booting = 1'b0;
   reg [31:0] i_init_vector = 32'h0;
   reg [15:0] i_pio_func = 16'h0, i_pio_dir = 16'h0, i_pio_out = 16'h0, e;
   reg [1:0] i_uart_tx = 2'h0;
   reg [4:0] i_int_n = 5'h1F;
   reg [3:0] i_cfg_raddr = 4'h0, b;
   reg [9:0] ext = 10'h0;
   reg [8:0] m;
   reg [35:0] q[$];
   integer failures = 0, samples_checked = 0, i, n;
   event go;
   wire [9:0] o_pad_out, o_pad_oe;
   wire [15:0] o_pio_in, o_pio_func, o_pio_dir, o_cfg_rdata;
   wire [4:0] o_int_req;
   wire [31:0] o_init_vector;
   wire o_uart_cts_n, o_uart_dsr_n, o_spi_data_in, o_nmi_req, o_cold_active;
   wire o_boot_busy, o_boot_done, miso;
   wire [9:0] drv = {ext[9:8], booting ? miso : ext[7], ext[6:0]};
   wire [9:0] i_pad_in = (o_pad_oe & o_pad_out) | (~o_pad_oe & drv);
   spm_pin_mux u_spm_pin_mux (.i_clock, .i_reset, .i_coldreset_n,
      .i_init_vector, .i_cfg_write, .i_pio_func, .i_pio_dir, .i_pio_out,
      .i_uart_tx, .i_uart_dtr_n, .i_uart_rts_n, .i_spi_data_out,
      .i_spi_clock, .i_spi_sel_n, .i_pad_in, .i_nmi_n, .i_int_n,
      .i_cfg_raddr, .o_pad_out, .o_pad_oe, .o_pio_in, .o_pio_func,
      .o_pio_dir, .o_uart_cts_n, .o_uart_dsr_n, .o_spi_data_in, .o_nmi_req,
      .o_int_req, .o_init_vector, .o_cold_active, .o_boot_busy,
      .o_boot_done, .o_cfg_rdata);
   spm_eeprom_model u_spm_eeprom_model (.i_sck(i_pad_in[8]),
      .i_sel(i_pad_in[9]), .i_mosi(i_pad_in[6]), .o_miso(miso));
   always #5 i_clock = ~i_clock;
   function [31:0] obs(input [3:0] k);
      case (k)
         0: obs = {o_pad_oe, o_pad_out & o_pad_oe};
         1: obs = o_pio_in;
         2: obs = {o_nmi_req, o_int_req, o_uart_cts_n, o_uart_dsr_n,
                   o_spi_data_in};
         3: obs = o_init_vector;
         4: obs = o_cfg_rdata;
         5: obs = {o_pio_func, o_pio_dir};
         default: obs = {o_boot_busy, o_boot_done, o_cold_active};
      endcase
   endfunction
   function [19:0] pad_exp(input [15:0] f, d, o);
      integer s;
      reg [3:0] p;
      reg [9:0] pv, oe, ov;
      begin
         pv = {i_spi_sel_n, i_spi_clock, 1'b0, i_spi_data_out, i_uart_rts_n,
               i_uart_dtr_n, 2'b00, i_uart_tx};
         for (s = 0; s < 10; s = s + 1) begin
            p = 4'(`SPM_PIO_OF_PAD >> (4 * s));
            oe[s] = f[p] ? 1'(`SPM_PERIPH_DRIVES >> s) : d[p];
            ov[s] = f[p] ? pv[s] : o[p];
         end
         pad_exp = {oe, ov & oe};
      end
   endfunction
   // Results are noted in order and compared by the watcher below
   task chk(input [3:0] k, input [31:0] v);
      begin
         q.push_back({k, v});
         -> go;
         #1;
      end
   endtask
   always @(go) begin
      samples_checked = samples_checked + 1;
      if (obs(q[0][35:32]) !== q[0][31:0]) begin
         failures = failures + 1;
         $display("Error at %0t: item %0d mismatch", $time, q[0][35:32]);
      end
      q.delete(0);
   end
   task final_report;
      begin
         $display("checks %0d mismatches %0d", samples_checked, failures);
         if (failures == 0 && samples_checked > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task wait_bit(input integer k, input integer lim);
      integer t;
      begin
         t = 0;
         while (((obs(6) >> k) & 32'h1) !== 32'h1 && t < lim) begin
            @(negedge i_clock);
            t = t + 1;
         end
         if (t == lim) begin
            failures = failures + 1;
            $display("Error at %0t: wait timed out", $time);
            final_report;
         end
      end
   endtask
   initial begin
      n = $urandom(67);
      // Let the first edge apply reset before looking at the outputs
      @(negedge i_clock);
      chk(0, {10'h340, 10'h200});
      chk(5, 32'h0000_0700);
      chk(6, 32'h1);
      repeat (7) @(negedge i_clock);
      i_reset = 1'b0;
      $display("reset test done");
      for (n = 0; n < 8; n = n + 1) begin
         @(negedge i_clock);
         {i_pio_func, i_pio_dir, i_pio_out} = 48'({$urandom, $urandom});
         if (n < 2) i_pio_func = n ? 16'h0000 : 16'hFFFF;
         {i_uart_tx, i_uart_dtr_n, i_uart_rts_n, i_spi_data_out, i_spi_clock,
          i_spi_sel_n, i_nmi_n, i_int_n, ext} = 23'($urandom);
         i_cfg_write = 1'b1;
         @(negedge i_clock);
         i_cfg_write = 1'b0;
         repeat (3) @(negedge i_clock);
         e = 16'h0000;
         for (i = 0; i < 10; i = i + 1) begin
            b = 4'(`SPM_PIO_OF_PAD >> (4 * i));
            // A general-purpose output reads back its own pad level
            if (!i_pio_func[b]) e[b] = i_pio_dir[b] ? i_pio_out[b] : drv[i];
         end
         m = {~i_nmi_n, ~i_int_n, !i_pio_func[15] | drv[2],
              !i_pio_func[14] | drv[3], i_pio_func[7] & drv[7]};
         chk(5, {i_pio_func, i_pio_dir});
         chk(0, pad_exp(i_pio_func, i_pio_dir, i_pio_out));
         chk(1, e);
         chk(2, m);
      end
      $display("function select test done");
      i_coldreset_n = 1'b0;
      i_init_vector = $urandom & 32'hFFFF_FFFE;
      // Writes during cold reset must be refused
      i_cfg_write = 1'b1;
      repeat (3) @(negedge i_clock);
      i_cfg_write = 1'b0;
      chk(3, i_init_vector);
      chk(5, 32'h0000_0700);
      chk(0, {10'h340, 10'h200});
      chk(6, 32'h1);
      i_coldreset_n = 1'b1;
      @(negedge i_clock);
      i_init_vector = ~i_init_vector;
      repeat (2) @(negedge i_clock);
      chk(3, ~i_init_vector);
      chk(6, 32'h0);
      $display("cold reset test done");
      booting = 1'b1;
      i_coldreset_n = 1'b0;
      i_init_vector = 32'h0000_0001;
      repeat (2) @(negedge i_clock);
      i_coldreset_n = 1'b1;
      wait_bit(2, 10);
      wait_bit(1, 50000);
      chk(6, 32'h2);
      for (i = 0; i < 16; i = i + 1) begin
         i_cfg_raddr = 4'(i);
         repeat (2) @(negedge i_clock);
         chk(4, {4{i_cfg_raddr}} ^ 16'h5A3C);
      end
      $display("boot test done");
      final_report;
   end
endmodule
bind spm_pin_mux spm_pin_mux_properties u_spm_pin_mux_properties (.i_clock,
   .i_reset, .i_coldreset_n, .i_init_vector, .i_cfg_write, .i_pio_func,
   .i_uart_tx, .i_int_n, .o_pad_out, .o_pad_oe, .o_pio_func, .o_int_req,
   .o_init_vector, .o_boot_busy);
